// ===== rtl/drb_pkg.sv
// drb_pkg: constants shared by the read-burst device model
// assumes x8 data, eight banks and a small row and column space
package drb_pkg;

  // geometry
  localparam int BANK_W = 3;
  localparam int NBANK  = 8;
  localparam int ROW_W  = 2;
  localparam int COL_W  = 5;
  localparam int ADDR_W = 14;
  localparam int DQ_W   = 8;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W - 1;
  localparam int MEM_DW = 2 * DQ_W;
  localparam int PIPE_D = 16;
  localparam int SYNC_W = NBANK + 1;

  // command codes as {ras_n, cas_n, we_n} with select low
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_LMR  = 3'h0;

  // load-mode targets on the bank address
  localparam logic [BANK_W-1:0] SEL_MODE     = 3'h0;
  localparam logic [BANK_W-1:0] SEL_EXT_MODE = 3'h1;

  // field positions
  localparam int AUTO_PRECHARGE_ADDRESS_BIT = 10;
  localparam int CL_LSB = 4;
  localparam int AL_LSB = 3;
  localparam int BL_LSB = 0;
  localparam int FLD_W  = 3;
  localparam logic [FLD_W-1:0] BL8_CODE = 3'h3;

  // reset values
  localparam logic [FLD_W-1:0] CL_RST = 3'h3;
  localparam logic [FLD_W-1:0] AL_RST = 3'h0;

  // burst length in clock cycles, minus one (BL/2 - 1)
  localparam logic [1:0] LAST_BL4 = 2'h1;
  localparam logic [1:0] LAST_BL8 = 2'h3;
  // clocks the burst engine runs ahead of the first data cycle
  localparam logic [3:0] TAP_OFS  = 4'h1;

  typedef enum logic [1:0] {
    DRB_IDLE  = 2'b01,
    DRB_BURST = 2'b10
  } drb_state_t;

endpackage

// ===== rtl/drb_sync.sv
// drb_sync: three-stage level synchroniser, one stage set per bit
// assumes inputs are quasi-static levels from another clock domain
`timescale 1ns/100ps
`default_nettype none
module drb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] level_o
);

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= level_i[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // only take a change once two settled stages agree
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          level_o[g] <= 1'b0;
        end else if (s2 == s3) begin
          level_o[g] <= s3;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== rtl/drb_mem.sv
// drb_mem: array of column pairs, written from the core clock, read at the link
// assumes the core loads contents only while no burst is running
`timescale 1ns/100ps
`default_nettype none
module drb_mem
  import drb_pkg::*;
(
  // core write side
  input  wire logic              clock_i,
  input  wire logic              wr_en_i,
  input  wire logic [MEM_AW-1:0] wr_addr_i,
  input  wire logic [MEM_DW-1:0] wr_data_i,
  // link read side
  input  wire logic              link_ck_i,
  input  wire logic              link_rst_n_i,
  input  wire logic [MEM_AW-1:0] rd_addr_i,
  output logic      [MEM_DW-1:0] rd_data_o
);

  logic [MEM_DW-1:0] cells [2**MEM_AW];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      cells[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read: one link cycle from address to data
  always_ff @(posedge link_ck_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= cells[rd_addr_i];
    end
  end

endmodule
`default_nettype wire

// ===== rtl/drb_read_burst.sv
// drb_read_burst: read path of a double-data-rate memory device
// assumes the controller drives commands on the link clock and keeps its spacing
// How it works
// - each read takes bank and column from the command, plus auto precharge choice.
// - auto precharge closes the row when its burst ends untruncated, streamed read following or not, else row stays open.
// - first element appears read latency clocks after the read command.
// - cas latency and additive latency come from the two load-mode registers.
// - further elements follow on each rising and falling clock crossing.
// - strobe driven low before data as preamble and low with the last element.
// - data and strobe lines released once a burst ends with nothing following.
// - a read BL/2 clocks later streams data with no gap.
// - burst-eight reads are truncated by a read landing on any clock of the burst, every two elements.
// - the interrupting read may pick any bank, row and auto precharge.
// - the auto precharge address bit high selects read with auto precharge.
`timescale 1ns/100ps
`default_nettype none
module drb_read_burst
  import drb_pkg::*;
(
  // core clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // core load port
  input  wire logic              load_valid_i,
  input  wire logic [MEM_AW-1:0] load_addr_i,
  input  wire logic [MEM_DW-1:0] load_data_i,
  // core status
  output logic      [NBANK-1:0]  bank_open_o,
  output logic                   read_busy_o,
  // link clock and command pins
  input  wire logic              link_ck_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic [BANK_W-1:0] ba_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // data pins
  input  wire logic [DQ_W-1:0]   dq_i,
  output logic      [DQ_W-1:0]   dq_o,
  output logic                   dq_oe_n_o,
  // strobe pair pins
  input  wire logic              dqs_i,
  output logic                   dqs_o,
  output logic                   dqs_oe_n_o,
  input  wire logic              dqs_n_i,
  output logic                   dqs_n_o,
  output logic                   dqs_n_oe_n_o
);

  typedef struct packed {
    logic              v;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic              bl8;
    logic              ap;
  } drb_rec_t;

  // link-side reset, released on the link clock
  logic [1:0] link_rst_q;
  logic       link_rst_n;

  // mode state
  logic [FLD_W-1:0] cas_latency;
  logic [FLD_W-1:0] additive_latency;
  logic             burst_is_8;
  logic [3:0]       read_latency;

  // bank state
  logic [NBANK-1:0]            bank_open;
  logic [NBANK-1:0][ROW_W-1:0] open_row;

  // command decode
  logic     sel;
  logic     is_read;
  logic     is_act;
  logic     is_pre;
  logic     is_lmr;
  drb_rec_t cmd_rec;

  // latency line and burst engine
  drb_rec_t [PIPE_D-1:0] pipe;
  drb_rec_t              tap;
  drb_state_t            state;
  drb_state_t            next_state;
  drb_rec_t              cur;
  logic [1:0]            ofs;
  logic                  issue;
  logic                  last_issue;
  logic                  issue_q;
  logic [MEM_AW-1:0]     rd_addr;
  logic [MEM_DW-1:0]     rd_data;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] last_of(input logic bl8);
    last_of = bl8 ? LAST_BL8 : LAST_BL4;
  endfunction

  // sequential order wraps inside the burst: one pair bit for four, two for eight
  function automatic logic [1:0] pair_of(input logic [1:0] start, input logic [1:0] off,
                                         input logic bl8);
    logic [1:0] sum;
    sum = start + off;
    pair_of = bl8 ? sum : {start[1], sum[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link reset synchroniser: assert at once, release on two link edges

  always_ff @(posedge link_ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_rst_q <= 2'h0;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_q[1];

  ////////////////////////////////////////////////////////////////////////
  // command decode

  assign sel     = !cs_n_i;
  assign is_read = sel && ({ras_n_i, cas_n_i, we_n_i} == CMD_READ);
  assign is_act  = sel && ({ras_n_i, cas_n_i, we_n_i} == CMD_ACT);
  assign is_pre  = sel && ({ras_n_i, cas_n_i, we_n_i} == CMD_PRE);
  assign is_lmr  = sel && ({ras_n_i, cas_n_i, we_n_i} == CMD_LMR);

  always_comb begin
    cmd_rec      = '0;
    cmd_rec.v    = is_read;
    cmd_rec.bank = ba_i;
    cmd_rec.row  = open_row[ba_i];
    cmd_rec.col  = addr_i[COL_W-1:0];
    cmd_rec.bl8  = burst_is_8;
    cmd_rec.ap   = addr_i[AUTO_PRECHARGE_ADDRESS_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // mode registers

  always_ff @(posedge link_ck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cas_latency      <= CL_RST;
      additive_latency <= AL_RST;
      burst_is_8       <= 1'b0;
    end else if (is_lmr) begin
      if (ba_i == SEL_MODE) begin
        cas_latency <= addr_i[CL_LSB +: FLD_W];
        burst_is_8  <= (addr_i[BL_LSB +: FLD_W] == BL8_CODE);
      end else if (ba_i == SEL_EXT_MODE) begin
        additive_latency <= addr_i[AL_LSB +: FLD_W];
      end
    end
  end

  assign read_latency = 4'(additive_latency) + 4'(cas_latency);

  ////////////////////////////////////////////////////////////////////////
  // bank rows; commands later in a cycle win over the closing burst

  always_ff @(posedge link_ck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bank_open <= '0;
      open_row  <= '0;
    end else begin
      if (state == DRB_BURST && last_issue && cur.ap && !tap.v) begin
        bank_open[cur.bank] <= 1'b0;
      end
      if (is_act) begin
        bank_open[ba_i] <= 1'b1;
        open_row[ba_i]  <= addr_i[ROW_W-1:0];
      end else if (is_pre) begin
        if (addr_i[AUTO_PRECHARGE_ADDRESS_BIT]) begin
          bank_open <= '0;
        end else begin
          bank_open[ba_i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latency line: slot k holds a read issued k clocks ago

  always_ff @(posedge link_ck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[PIPE_D-2:0], cmd_rec};
    end
  end

  // engine starts one clock early to cover the registered array read
  // latency below two leaves no room for the preamble, so no output
  always_comb begin
    if (read_latency <= TAP_OFS) begin
      tap = '0;
    end else begin
      tap = pipe[read_latency - TAP_OFS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst engine: a new tap always reloads, which gives streaming and truncation

  assign issue      = tap.v || (state == DRB_BURST);
  assign last_issue = (ofs == last_of(cur.bl8));

  always_comb begin
    next_state = state;
    unique case (state)
      DRB_IDLE: begin
        if (tap.v) begin
          next_state = DRB_BURST;
        end
      end
      DRB_BURST: begin
        if (!tap.v && last_issue) begin
          next_state = DRB_IDLE;
        end
      end
      default: begin
        next_state = DRB_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_ck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= DRB_IDLE;
      cur   <= '0;
      ofs   <= 2'h0;
    end else begin
      state <= next_state;
      if (tap.v) begin
        cur <= tap;
        ofs <= 2'h1;
      end else if (state == DRB_BURST) begin
        ofs <= ofs + 2'h1;
      end
    end
  end

  // the pair issued this cycle comes from the tap on a reload
  always_comb begin
    if (tap.v) begin
      rd_addr = {tap.bank, tap.row, tap.col[COL_W-1:3],
                 pair_of(tap.col[2:1], 2'h0, tap.bl8)};
    end else begin
      rd_addr = {cur.bank, cur.row, cur.col[COL_W-1:3],
                 pair_of(cur.col[2:1], ofs, cur.bl8)};
    end
  end

  drb_mem u_mem (
    .clock_i      (clock_i),
    .wr_en_i      (load_valid_i),
    .wr_addr_i    (load_addr_i),
    .wr_data_i    (load_data_i),
    .link_ck_i    (link_ck_i),
    .link_rst_n_i (link_rst_n),
    .rd_addr_i    (rd_addr),
    .rd_data_o    (rd_data)
  );

  always_ff @(posedge link_ck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      issue_q <= 1'b0;
    end else begin
      issue_q <= issue;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins: even column in the low half, odd column in the high half

  // the clock level picks between two flops; cheap, but edges carry a short skew
  assign dq_o         = link_ck_i ? rd_data[DQ_W-1:0] : rd_data[MEM_DW-1:DQ_W];
  assign dq_oe_n_o    = !issue_q;
  // tap cycle drives the strobe low ahead of data; low half of last beat is postamble
  assign dqs_o        = issue_q && link_ck_i;
  assign dqs_n_o      = !dqs_o;
  assign dqs_oe_n_o   = !(issue_q || tap.v);
  assign dqs_n_oe_n_o = dqs_oe_n_o;

  ////////////////////////////////////////////////////////////////////////
  // status back to the core clock

  drb_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .level_i ({issue_q || (state == DRB_BURST), bank_open}),
    .level_o ({read_busy_o, bank_open_o})
  );

endmodule
`default_nettype wire

// ===== dv/drb_read_burst_properties.sv
// drb_read_burst_properties: link timing checks on the read burst device
// assumes a bind to drb_read_burst, mode fields as placed in drb_pkg
`timescale 1ns/100ps
`default_nettype none
module drb_checker
  import drb_pkg::*;
(
  // reset and device clock
  input wire logic              rst_n_i,
  input wire logic              link_ck_i,
  // command pins
  input wire logic              cs_n_i,
  input wire logic              ras_n_i,
  input wire logic              cas_n_i,
  input wire logic              we_n_i,
  input wire logic [BANK_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // data and strobe pins
  input wire logic              dq_oe_n_o,
  input wire logic              dqs_o,
  input wire logic              dqs_oe_n_o,
  input wire logic              dqs_n_o,
  input wire logic              dqs_n_oe_n_o
);
  logic [FLD_W-1:0] cas_lat;
  logic [FLD_W-1:0] add_lat;
  logic             bl8;
  logic             rd_cmd;
  logic             lmr_cmd;
  logic [4:0]       rl;
  logic [31:0]      dq_exp;
  logic [31:0]      qs_exp;
  assign rd_cmd  = !cs_n_i && {ras_n_i, cas_n_i, we_n_i} == CMD_READ;
  assign lmr_cmd = !cs_n_i && {ras_n_i, cas_n_i, we_n_i} == CMD_LMR;
  assign rl      = 5'(cas_lat) + 5'(add_lat);
  ////////////////////////////////////////////////////////////
  // shadow of the two mode registers
  always_ff @(posedge link_ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cas_lat <= CL_RST;
      add_lat <= AL_RST;
      bl8     <= 1'b0;
    end else if (lmr_cmd && ba_i == SEL_MODE) begin
      cas_lat <= addr_i[CL_LSB +: FLD_W];
      bl8     <= addr_i[BL_LSB +: FLD_W] == BL8_CODE;
    end else if (lmr_cmd && ba_i == SEL_EXT_MODE) begin
      add_lat <= addr_i[AL_LSB +: FLD_W];
    end
  end
  // masks are or-ed: a truncating read only extends the drive window
  always_ff @(posedge link_ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_exp <= '0;
      qs_exp <= '0;
    end else begin
      dq_exp <= (dq_exp >> 1) | ((rd_cmd && rl > 5'h1) ? ((bl8 ? 32'hf : 32'h3) << rl) : '0);
      qs_exp <= (qs_exp >> 1) | ((rd_cmd && rl > 5'h1) ? ((bl8 ? 32'h1f : 32'h7) << (rl - 5'h1)) : '0);
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge link_ck_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_plain;
    rd_cmd && rl == 5'h3 && !bl8 && !dq_exp[3];
  endsequence
  sequence s_frame;
    (!dqs_oe_n_o && dq_oe_n_o) ##1 (!dq_oe_n_o) [*2];
  endsequence
  frame_place_a: assert property (s_rd_plain |-> ##3 s_frame)
    else $error("burst frame misplaced");
  data_window_a: assert property (dq_oe_n_o != dq_exp[0])
    else $error("data drive window wrong");
  strobe_window_a: assert property (dqs_oe_n_o != qs_exp[0])
    else $error("strobe drive window wrong");
  strobe_pair_a: assert property (dqs_n_oe_n_o == dqs_oe_n_o)
    else $error("strobe enables differ");
  strobe_invert_a: assert property (dqs_n_o != dqs_o)
    else $error("strobe pair not inverse");
  strobe_low_a: assert property (!dqs_oe_n_o |-> !dqs_o)
    else $error("strobe not low at rise");
  preamble_first_a: assert property ($fell(dq_oe_n_o) |-> !$past(dqs_oe_n_o))
    else $error("data without preamble");
  strobe_high_a: assert property (@(negedge link_ck_i) disable iff (!rst_n_i)
    !dq_oe_n_o |-> dqs_o) else $error("strobe not high at fall");
endmodule
bind drb_read_burst drb_checker u_chk (.rst_n_i(rst_n_i), .link_ck_i(link_ck_i), .cs_n_i(cs_n_i),
  .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i),
  .dq_oe_n_o(dq_oe_n_o), .dqs_o(dqs_o), .dqs_oe_n_o(dqs_oe_n_o), .dqs_n_o(dqs_n_o),
  .dqs_n_oe_n_o(dqs_n_oe_n_o));
`default_nettype wire

// ===== dv/drb_ctl_model.sv
// drb_ctl_model: controller side of the link, makes the device clock
// assumes the caller spaces commands; captures read data off the pins
`timescale 1ns/100ps
`default_nettype none
module drb_ctl_model
  import drb_pkg::*;
(
  // device clock and command pins
  output logic                 link_ck_o,
  output logic                 cs_n_o,
  output logic                 ras_n_o,
  output logic                 cas_n_o,
  output logic                 we_n_o,
  output logic [BANK_W-1:0]    ba_o,
  output logic [ADDR_W-1:0]    addr_o,
  // read data
  input  wire logic [DQ_W-1:0] dq_i,
  input  wire logic            dq_oe_n_i
);
  logic [DQ_W-1:0] got[$];
  // device clock runs free, also between bursts
  initial begin
    link_ck_o = 1'b0;
    #1.3;
    forever #3 link_ck_o = ~link_ck_o;
  end
  initial begin
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o} = 3'h7;
    ba_o = '0;
    addr_o = '0;
  end
  // sample mid half-cycle, clear of both edges
  always @(posedge link_ck_o) begin
    #1.5;
    if (dq_oe_n_i === 1'b0) got.push_back(dq_i);
    @(negedge link_ck_o);
    #1.5;
    if (dq_oe_n_i === 1'b0) got.push_back(dq_i);
  end
  // no write command exists here; gap of 2 or more keeps strobes apart
  task automatic cmd(input logic [2:0] code, input logic [BANK_W-1:0] bank,
                     input logic [ADDR_W-1:0] adr, input int gap);
    cs_n_o = 1'b0;
    {ras_n_o, cas_n_o, we_n_o} = code;
    ba_o = bank;
    addr_o = adr;
    @(negedge link_ck_o);
    cs_n_o = 1'b1;
    // deselected lines change rather than keep the old value
    {ras_n_o, cas_n_o, we_n_o} = ~code;
    ba_o = ~bank;
    addr_o = ~adr;
    repeat (gap - 1) @(negedge link_ck_o);
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// testbench: read bursts through the controller model, checked on return
// assumes drb_ctl_model makes the device clock and captures read data
`timescale 1ns/100ps
`default_nettype none
module testbench
  import drb_pkg::*;
;
  localparam int ROW_PRE_CYC = 4;
  localparam int RTP_CYC = 2;
  logic              clock_i, rst_n_i, load_valid_i, read_busy_o, link_ck, cs_n, ras_n, cas_n, we_n;
  logic [MEM_AW-1:0] load_addr_i;
  logic [MEM_DW-1:0] load_data_i;
  logic [NBANK-1:0]  bank_open_o;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   dq_o;
  logic              dq_oe_n_o, dqs_o, dqs_oe_n_o, dqs_n_o, dqs_n_oe_n_o;
  wire  [DQ_W-1:0]   dq_w = dq_oe_n_o ? 8'hzz : dq_o;
  wire               dqs_w = dqs_oe_n_o ? 1'bz : dqs_o;
  wire               dqsn_w = dqs_n_oe_n_o ? 1'bz : dqs_n_o;
  int                fail_count = 0, checks = 0, cycles = 0;
  drb_read_burst u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_valid_i(load_valid_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i), .bank_open_o(bank_open_o), .read_busy_o(read_busy_o),
    .link_ck_i(link_ck), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba),
    .addr_i(addr), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dqs_i(dqs_w), .dqs_o(dqs_o),
    .dqs_oe_n_o(dqs_oe_n_o), .dqs_n_i(dqsn_w), .dqs_n_o(dqs_n_o), .dqs_n_oe_n_o(dqs_n_oe_n_o));
  drb_ctl_model u_ctl (.link_ck_o(link_ck), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
    .ba_o(ba), .addr_o(addr), .dq_i(dq_w), .dq_oe_n_i(dq_oe_n_o));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  function automatic logic [7:0] eb(input logic [2:0] b, input logic [1:0] r, input logic [4:0] c);
    return {b, c} ^ {r, 6'h00};
  endfunction
  function automatic logic [ADDR_W-1:0] ca(input logic [4:0] c, input logic ap);
    return ADDR_W'(c) | (ADDR_W'(ap) << AUTO_PRECHARGE_ADDRESS_BIT);
  endfunction
  // waits until data has been quiet a while and status has caught up
  task automatic settle();
    int quiet;
    int n;
    quiet = 0;
    for (n = 0; n < 300 && !(quiet >= 10 && read_busy_o === 1'b0); n++) begin
      @(negedge clock_i);
      quiet = (dq_oe_n_o === 1'b1) ? quiet + 1 : 0;
    end
    chk("settle", 32'h0, 32'(n >= 300));
    @(negedge link_ck);
  endtask
  task automatic burst(input logic [2:0] b, input logic [1:0] r, input logic [4:0] c, input int n, input int cnt);
    logic [4:0] col;
    for (int k = 0; k < cnt; k++) begin
      col = (c & ~5'(n - 1)) | 5'((c + k) % n);
      chk("dq", eb(b, r, col), u_ctl.got.size() > 0 ? u_ctl.got.pop_front() : 8'hxx);
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_bl4();
    u_ctl.cmd(CMD_ACT, 3'h2, 14'h0001, 2);
    u_ctl.cmd(CMD_READ, 3'h2, ca(5'h0a, 1'b0), 2);
    u_ctl.cmd(CMD_READ, 3'h2, ca(5'h0c, 1'b0), 2);
    settle();
    burst(3'h2, 2'h1, 5'h0a, 4, 4);
    burst(3'h2, 2'h1, 5'h0c, 4, 4);
    chk("open", 32'h4, bank_open_o);
    u_ctl.cmd(CMD_READ, 3'h2, ca(5'h06, 1'b1), 2);
    settle();
    burst(3'h2, 2'h1, 5'h06, 4, 4);
    chk("open", 32'h0, bank_open_o);
  endtask
  task automatic t_bl8();
    u_ctl.cmd(CMD_LMR, SEL_MODE, 14'h0043, 2);
    u_ctl.cmd(CMD_LMR, SEL_EXT_MODE, 14'h0010, 2);
    u_ctl.cmd(CMD_ACT, 3'h5, 14'h0002, 2);
    u_ctl.cmd(CMD_ACT, 3'h3, 14'h0000, 2);
    u_ctl.cmd(CMD_READ, 3'h5, ca(5'h12, 1'b0), 4);
    u_ctl.cmd(CMD_READ, 3'h5, ca(5'h00, 1'b0), 2);
    u_ctl.cmd(CMD_READ, 3'h3, ca(5'h08, 1'b1), 2);
    settle();
    burst(3'h5, 2'h2, 5'h12, 8, 8);
    burst(3'h5, 2'h2, 5'h00, 8, 4);
    burst(3'h3, 2'h0, 5'h08, 8, 8);
    chk("open", 32'h20, bank_open_o);
  endtask
  task automatic t_pre();
    u_ctl.cmd(CMD_ACT, 3'h6, 14'h0001, 2);
    u_ctl.cmd(CMD_READ, 3'h5, ca(5'h18, 1'b0), 4 + (RTP_CYC > 2 ? RTP_CYC : 2));
    u_ctl.cmd(CMD_PRE, 3'h5, 14'h0000, ROW_PRE_CYC);
    settle();
    burst(3'h5, 2'h2, 5'h18, 8, 8);
    chk("open", 32'h40, bank_open_o);
    u_ctl.cmd(CMD_PRE, 3'h0, ca(5'h00, 1'b1), ROW_PRE_CYC);
    settle();
    chk("open", 32'h0, bank_open_o);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    load_valid_i = 1'b0;
    load_addr_i = '0;
    load_data_i = '0;
    repeat (20) @(negedge clock_i);
    rst_n_i = 1'b1;
    settle();
    chk("idle", 32'h1d, {bank_open_o, read_busy_o, dq_oe_n_o, dqs_oe_n_o, dqs_n_oe_n_o, dqs_o, dqs_n_o});
    for (int i = 0; i < 512; i++) begin
      @(negedge clock_i);
      load_valid_i = 1'b1;
      load_addr_i = MEM_AW'(i);
      load_data_i = {eb(3'(i >> 6), 2'(i >> 4), {4'(i), 1'b1}), eb(3'(i >> 6), 2'(i >> 4), {4'(i), 1'b0})};
    end
    @(negedge clock_i);
    load_valid_i = 1'b0;
    settle();
    t_bl4();
    t_bl8();
    t_pre();
    chk("left", 32'h0, u_ctl.got.size());
    final_report();
  end
endmodule
`default_nettype wire
